//--- grs_dev.sv
// Device end: serial slave holding two sets of fourteen channel codes.
// Assumes the bus lines and the strap pins are asynchronous to clk.
`default_nettype none

module grs_dev (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	grs_bus_if.dev bus,
	input wire logic framing_mode_pin,
	input wire logic addr_lsb_pin,
	input wire logic curve_sel_pin,
	output logic [grs_pkg::NCH-1:0][7:0] chan_codes
);

	// ***********************************
	// State
	// ***********************************
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] mode_s;
		logic [1:0] lsb_s;
		logic [1:0] curve_s;
		logic scl_p;
		logic sda_p;
		grs_pkg::grs_dev_st_e st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [1:0] bidx;
		logic [3:0] ch;
		logic rd;
		logic wset;
		logic rset;
		logic mack;
		logic oe;
		// Both code sets; the written set and the shown set are chosen independently
		logic [1:0][grs_pkg::NCH-1:0][7:0] mem;
		grs_pkg::grs_codes_t codes;
	} grs_dev_s;

	grs_dev_s q;
	grs_dev_s d;
	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic ack;
	logic [7:0] nb;

	// Read-back source; the set comes from the last write's control byte
	function automatic logic [7:0] rd_byte(input logic [3:0] ch);
		if (ch < grs_pkg::CH_END) begin
			return q.mem[q.rset][ch];
		end
		// Reads past the last channel return a fixed filler
		return grs_pkg::FILL_CODE;
	endfunction : rd_byte

	// ***********************************
	// Next state
	// ***********************************
	always_comb begin
		d = q;
		ack = 1'b0;
		nb = 8'h00;
		d.scl_s = {q.scl_s[0], bus.scl};
		d.sda_s = {q.sda_s[0], bus.sda};
		d.mode_s = {q.mode_s[0], framing_mode_pin};
		d.lsb_s = {q.lsb_s[0], addr_lsb_pin};
		d.curve_s = {q.curve_s[0], curve_sel_pin};
		scl = q.scl_s[1];
		sda = q.sda_s[1];
		d.scl_p = scl;
		d.sda_p = sda;
		rise = scl && !q.scl_p;
		fall = !scl && q.scl_p;
		// Line changes with the clock high are frame marks, never data
		start = scl && q.scl_p && q.sda_p && !sda;
		stop = scl && q.scl_p && !q.sda_p && sda;
		// Output mux follows the curve pin whenever ce is high
		d.codes = q.mem[q.curve_s[1]];

		if (start) begin
			d.st = grs_pkg::DEV_RX;
			d.bitc = 4'h0;
			d.bidx = 2'h0;
			d.mack = 1'b0;
			d.oe = 1'b0;
		end else if (stop) begin
			d.st = grs_pkg::DEV_IDLE;
			d.oe = 1'b0;
		end else begin
			case (q.st)
				grs_pkg::DEV_RX: begin
					if (rise && q.bitc != grs_pkg::ACK_BIT) begin
						d.sh = {q.sh[6:0], sda};
						d.bitc = q.bitc + 4'h1;
					end else if (fall && q.bitc == grs_pkg::ACK_BIT) begin
						if (q.bidx == 2'h0) begin
							// Per-register framing is not supported, so a low mode pin never answers
							ack = q.mode_s[1] && (q.sh[7:1] == {grs_pkg::ADDR_HI, q.lsb_s[1]});
							d.rd = q.sh[0];
							d.ch = 4'h0;
						end else if (q.bidx == 2'h1 && !q.rd) begin
							ack = 1'b1;
							d.wset = q.sh[grs_pkg::WSET_BIT];
							d.rset = q.sh[grs_pkg::RSET_BIT];
						end else begin
							ack = 1'b1;
							if (q.ch < grs_pkg::CH_END) begin
								d.mem[q.wset][q.ch] = q.sh;
								d.ch = q.ch + 4'h1;
							end
						end
						if (q.bidx != grs_pkg::BIDX_DATA) begin
							d.bidx = q.bidx + 2'h1;
						end
						// The pull starts just after the clock falls, well inside the low half
						d.oe = ack;
						d.st = ack ? grs_pkg::DEV_RACK : grs_pkg::DEV_IDLE;
					end
				end
				grs_pkg::DEV_RACK: begin
					if (fall) begin
						d.bitc = 4'h0;
						if (q.rd) begin
							nb = rd_byte(q.ch);
							d.sh = nb;
							d.oe = !nb[7];
							d.st = grs_pkg::DEV_TX;
						end else begin
							d.oe = 1'b0;
							d.st = grs_pkg::DEV_RX;
						end
					end
				end
				grs_pkg::DEV_TX: begin
					if (fall) begin
						if (q.bitc == grs_pkg::LAST_DATA_BIT) begin
							d.oe = 1'b0;
							d.mack = 1'b0;
							d.st = grs_pkg::DEV_TACK;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.oe = !q.sh[6];
							d.bitc = q.bitc + 4'h1;
						end
					end
				end
				grs_pkg::DEV_TACK: begin
					if (rise) begin
						if (sda) begin
							// Released line: master ends the read
							d.st = grs_pkg::DEV_IDLE;
						end else begin
							d.mack = 1'b1;
							// Index stops at the end so later reads get the filler
							if (q.ch < grs_pkg::CH_END) begin
								d.ch = q.ch + 4'h1;
							end
						end
					end else if (fall && q.mack) begin
						nb = rd_byte(q.ch);
						d.sh = nb;
						d.oe = !nb[7];
						d.bitc = 4'h0;
						d.mack = 1'b0;
						d.st = grs_pkg::DEV_TX;
					end
				end
				default: begin
					d.oe = 1'b0;
				end
			endcase
		end
	end

	// ***********************************
	// Registers
	// ***********************************
	// Reset wins over the clock enable, so a frozen block can still be cleared
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			// Sync stages start at the idle bus level so release never looks like an edge
			q.scl_s <= 2'h3;
			q.sda_s <= 2'h3;
			q.scl_p <= 1'b1;
			q.sda_p <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// ***********************************
	// Outputs
	// ***********************************
	// Open drain: the value is always low, only the enable moves
	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe = q.oe;
	assign chan_codes = q.codes;

endmodule : grs_dev

`default_nettype wire

//--- grs_pkg.sv
// Shared constants and types for the reference generator serial link.
// Assumes one system clock at 250 MHz on both ends and open-drain bus lines.
`default_nettype none

package grs_pkg;

	// ***********************************
	// Link constants
	// ***********************************
	localparam int NCH = 14;
	localparam logic [3:0] CH_END = 4'he;
	localparam logic [5:0] ADDR_HI = 6'h3a;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam int WSET_BIT = 1;
	localparam int RSET_BIT = 2;
	localparam logic [7:0] FILL_CODE = 8'h00;
	localparam logic [4:0] LAST_WR = 5'h0f;
	localparam logic [4:0] LAST_RD = 5'h0e;
	localparam logic [1:0] BIDX_DATA = 2'h2;

	// ***********************************
	// Timing
	// ***********************************
	localparam int CLK_KHZ = 250_000;
	localparam int SCL_MAX_KHZ = 400;
	// Quarter of the shortest legal bit period, rounded up so the rate stays at or below the limit
	localparam int QTR_CYC = (CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

	// ***********************************
	// Types
	// ***********************************
	typedef logic [NCH-1:0][7:0] grs_codes_t;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_RX = 3'h1,
		DEV_RACK = 3'h3,
		DEV_TX = 3'h2,
		DEV_TACK = 3'h6
	} grs_dev_st_e;

	typedef enum logic [1:0] {
		HST_IDLE = 2'h0,
		HST_START = 2'h1,
		HST_BIT = 2'h3,
		HST_STOP = 2'h2
	} grs_host_st_e;

endpackage : grs_pkg

`default_nettype wire

//--- grs_bus_if.sv
// Two-wire bus between master and device ends.
// Assumes open-drain lines with pull-ups; an enable pulls the line to its output value.
`default_nettype none

interface grs_bus_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND of the drivers, pull-up when nobody drives
	assign scl = h_scl_oe ? h_scl_o : 1'b1;
	assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

	modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
	modport host (input sda, output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe);
endinterface : grs_bus_if

`default_nettype wire

//--- grs_host.sv
// Master end: runs one bulk write or bulk read of all fourteen codes per command.
// Assumes the data line is asynchronous to clk; the clock line is driven here only.
`default_nettype none

module grs_host (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	grs_bus_if.host bus,
	input wire logic cmd_valid,
	input wire logic cmd_rw,
	input wire logic cmd_addr_lsb,
	input wire logic [7:0] cmd_ctrl,
	input wire logic [grs_pkg::NCH-1:0][7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_nack,
	output logic [grs_pkg::NCH-1:0][7:0] rsp_rdata
);

	// ***********************************
	// State
	// ***********************************
	typedef struct packed {
		logic [1:0] sda_s;
		grs_pkg::grs_host_st_e st;
		logic [7:0] qc;
		logic [1:0] ph;
		logic [3:0] bitc;
		logic [4:0] byt;
		logic rw;
		logic lsb;
		logic [7:0] ctrl;
		grs_pkg::grs_codes_t wd;
		grs_pkg::grs_codes_t rdat;
		logic [7:0] sh;
		logic ackok;
		logic scl_oe;
		logic sda_oe;
		logic rdy;
		logic rsp_v;
		logic nack;
	} grs_host_s;

	grs_host_s q;
	grs_host_s d;
	logic tick;
	logic sda;
	logic tx;
	logic [4:0] last;
	logic [7:0] nb;

	function automatic logic [7:0] tx_byte(input logic [4:0] n);
		if (n == 5'h00) begin
			return {grs_pkg::ADDR_HI, q.lsb, q.rw};
		end else if (n == 5'h01) begin
			return q.ctrl;
		end
		return q.wd[n - 5'h02];
	endfunction : tx_byte

	// ***********************************
	// Next state
	// ***********************************
	always_comb begin
		d = q;
		nb = 8'h00;
		tick = (q.qc == grs_pkg::QTR_LAST);
		sda = q.sda_s[1];
		tx = (q.byt == 5'h00) || !q.rw;
		last = q.rw ? grs_pkg::LAST_RD : grs_pkg::LAST_WR;
		d.sda_s = {q.sda_s[0], bus.sda};
		d.rsp_v = 1'b0;
		if (q.st != grs_pkg::HST_IDLE) begin
			d.qc = tick ? 8'h00 : q.qc + 8'h01;
		end
		case (q.st)
			grs_pkg::HST_IDLE: begin
				if (cmd_valid) begin
					d.st = grs_pkg::HST_START;
					d.rdy = 1'b0;
					d.rw = cmd_rw;
					d.lsb = cmd_addr_lsb;
					d.ctrl = cmd_ctrl;
					d.wd = cmd_wdata;
					d.nack = 1'b0;
					d.sda_oe = 1'b1;
					d.ph = 2'h0;
					d.qc = 8'h00;
				end
			end
			grs_pkg::HST_START: begin
				if (tick && q.ph == 2'h0) begin
					d.scl_oe = 1'b1;
					d.ph = 2'h1;
				end else if (tick) begin
					nb = tx_byte(5'h00);
					d.sh = nb;
					d.sda_oe = !nb[7];
					d.bitc = 4'h0;
					d.byt = 5'h00;
					d.ph = 2'h0;
					d.st = grs_pkg::HST_BIT;
				end
			end
			grs_pkg::HST_BIT: begin
				if (tick) begin
					d.ph = q.ph + 2'h1;
					case (q.ph)
						2'h0: d.scl_oe = 1'b0;
						2'h1: begin
							if (q.bitc == grs_pkg::ACK_BIT) begin
								d.ackok = !sda;
							end else if (!tx) begin
								d.sh = {q.sh[6:0], sda};
							end
						end
						2'h2: d.scl_oe = 1'b1;
						default: begin
							// Data moves a quarter period after the clock falls
							if (q.bitc == grs_pkg::ACK_BIT) begin
								if (!tx) begin
									d.rdat[q.byt - 5'h01] = q.sh;
								end
								if ((tx && !q.ackok) || q.byt == last) begin
									d.st = grs_pkg::HST_STOP;
									d.nack = tx && !q.ackok;
									d.sda_oe = 1'b1;
									d.ph = 2'h0;
								end else begin
									d.byt = q.byt + 5'h01;
									d.bitc = 4'h0;
									nb = tx_byte(d.byt);
									d.sh = nb;
									d.sda_oe = q.rw ? 1'b0 : !nb[7];
								end
							end else begin
								d.bitc = q.bitc + 4'h1;
								if (tx) begin
									d.sh = {q.sh[6:0], 1'b0};
								end
								if (q.bitc == grs_pkg::LAST_DATA_BIT) begin
									d.sda_oe = tx ? 1'b0 : (q.byt != last);
								end else begin
									d.sda_oe = tx ? !q.sh[6] : 1'b0;
								end
							end
						end
					endcase
				end
			end
			grs_pkg::HST_STOP: begin
				if (tick) begin
					d.ph = q.ph + 2'h1;
					if (q.ph == 2'h0) begin
						d.scl_oe = 1'b0;
					end else if (q.ph == 2'h1) begin
						d.sda_oe = 1'b0;
					end else begin
						d.st = grs_pkg::HST_IDLE;
						d.rdy = 1'b1;
						d.rsp_v = 1'b1;
					end
				end
			end
			default: d.st = grs_pkg::HST_IDLE;
		endcase
	end

	// ***********************************
	// Registers
	// ***********************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			// Ready is the only state bit that comes out of reset high
			q.rdy <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign bus.h_scl_o = 1'b0;
	assign bus.h_scl_oe = q.scl_oe;
	assign bus.h_sda_o = 1'b0;
	assign bus.h_sda_oe = q.sda_oe;
	assign cmd_ready = q.rdy;
	assign rsp_valid = q.rsp_v;
	assign rsp_nack = q.nack;
	assign rsp_rdata = q.rdat;

endmodule : grs_host

`default_nettype wire

//--- grs_link_asserts.sv
// Checker for the two-wire link joining the master and device ends.
// Assumes the resolved lines and the drive enables arrive as plain inputs.
`default_nettype none

module grs_link_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic h_scl_oe,
	input wire logic h_sda_oe,
	input wire logic d_sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Clock edge spacing
	// ****
	logic scl_q;
	logic [9:0] gap_q;

	// Saturates so the first edge after reset never looks too close
	always_ff @(posedge clk) begin
		scl_q <= scl;
		if (!rst_n) gap_q <= 10'h3ff;
		else if (scl != scl_q) gap_q <= 10'h000;
		else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_scl_spacing: assert property (scl != scl_q |-> gap_q >= 10'h12c)
		else $error("serial clock edges too close");
	a_scl_low_half: assert property ($fell(scl) |-> ##[300:330] $rose(scl))
		else $error("serial clock low time wrong");
	a_dev_change_low: assert property ($changed(d_sda_oe) |-> !scl && !$past(scl, 2))
		else $error("device data moved near clock high");
	a_dev_hold_high: assert property ($rose(scl) |=> $stable(d_sda_oe) [*8])
		else $error("device data moved while clock high");
	a_start_by_host: assert property ($fell(sda) && scl && $past(scl) |-> h_sda_oe && !d_sda_oe)
		else $error("start not made by master");
	a_start_form: assert property ($fell(sda) && scl && $past(scl) |-> ##[140:170] $fell(scl))
		else $error("clock not pulled after start");
	a_stop_free: assert property ($rose(sda) && scl && $past(scl) |-> !d_sda_oe && $past(scl, 100))
		else $error("stop with device driving");
	a_idle_high: assert property ($rose(sda) && scl && $past(scl) |=> (scl && sda) [*8])
		else $error("lines not idle after stop");
endmodule : grs_link_asserts

`default_nettype wire

//--- tb_gamma_ref_i2c_slave.sv
// Bench joining master and device ends, checked against a code-set model.
// Assumes grs_pkg, grs_bus_if, grs_dev, grs_host and the link checker.
`default_nettype none

module tb_gamma_ref_i2c_slave;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mode_pin = 1'b1;
	logic lsb_pin = 1'b0;
	logic curve_pin = 1'b0;
	logic ce = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_rw = 1'b0;
	logic cmd_addr_lsb = 1'b0;
	logic [7:0] cmd_ctrl = 8'h00;
	logic [7:0] c;
	logic cmd_ready, rsp_valid, rsp_nack;
	grs_pkg::grs_codes_t cmd_wdata = '0;
	grs_pkg::grs_codes_t rsp_rdata, chan_codes;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int model[2][14];

	always #2 clk = ~clk;

	grs_bus_if bus_i ();
	grs_dev u_grs_dev (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus_i.dev), .framing_mode_pin(mode_pin),
		.addr_lsb_pin(lsb_pin), .curve_sel_pin(curve_pin), .chan_codes(chan_codes));
	grs_host u_grs_host (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus_i.host), .cmd_valid(cmd_valid),
		.cmd_rw(cmd_rw), .cmd_addr_lsb(cmd_addr_lsb), .cmd_ctrl(cmd_ctrl), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
	grs_link_asserts u_grs_link_asserts (.clk(clk), .rst_n(rst_n), .scl(bus_i.scl), .sda(bus_i.sda),
		.h_scl_oe(bus_i.h_scl_oe), .h_sda_oe(bus_i.h_sda_oe), .d_sda_oe(bus_i.d_sda_oe));

	// ****
	// Checking and closing
	// ****
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// A full write takes some 90k cycles, so the ceiling covers about two long transfers
	always @(posedge clk) begin
		cycles++;
		if (cycles == 220000) begin
			num_errors++;
			give_verdict();
		end
	end

	// Curve pin passes two sync flops, so allow a few cycles before comparing
	task automatic codes(input int s);
		repeat (8) @(negedge clk);
		for (int i = 0; i < 14; i++) chk(chan_codes[i], 8'(model[s][i]));
	endtask : codes

	task automatic xfer(input logic rw, input logic lsb, input logic [7:0] ctrl);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_rw <= rw;
		cmd_addr_lsb <= lsb;
		cmd_ctrl <= ctrl;
		for (int i = 0; i < 14; i++) cmd_wdata[i] <= 8'(model[ctrl[1]][i]);
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		chk({7'h00, cmd_ready}, 8'h00);
		while (rsp_valid !== 1'b1) @(negedge clk);
		chk({7'h00, cmd_ready}, 8'h01);
	endtask : xfer

	// ****
	// Main sequence
	// ****
	initial begin
		void'($urandom(32'h74a4_2e7c));
		for (int i = 0; i < 14; i++) model[0][i] = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		lsb_pin <= 1'($urandom);
		codes(0);
		for (int i = 0; i < 14; i++) model[1][i] = $urandom_range(255);
		c = 8'($urandom) | 8'h06;
		xfer(1'b0, lsb_pin, c);
		chk({7'h00, rsp_nack}, 8'h00);
		codes(0);
		@(posedge clk);
		curve_pin <= 1'b1;
		codes(1);
		// A low enable must hold the shown set although the curve pin moves
		@(posedge clk);
		ce <= 1'b0;
		curve_pin <= 1'b0;
		codes(1);
		@(posedge clk);
		ce <= 1'b1;
		codes(0);
		@(posedge clk);
		curve_pin <= 1'b1;
		codes(1);
		xfer(1'b1, lsb_pin, 8'h00);
		for (int i = 0; i < 14; i++) chk(rsp_rdata[i], 8'(model[1][i]));
		chk({7'h00, rsp_nack}, 8'h00);
		xfer(1'b0, ~lsb_pin, c & 8'hf9);
		chk({7'h00, rsp_nack}, 8'h01);
		codes(1);
		@(posedge clk);
		mode_pin <= 1'b0;
		repeat (8) @(posedge clk);
		xfer(1'b0, lsb_pin, 8'h00);
		chk({7'h00, rsp_nack}, 8'h01);
		codes(1);
		give_verdict();
	end
endmodule : tb_gamma_ref_i2c_slave

`default_nettype wire
